//--- core/lcd_pkg.sv
// Package: register map, field layout and reset values of the link configuration bank
package lcd_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [11:0] LCD_IDX_VERSION_SAMPLES = 12'h459;
	localparam logic [11:0] LCD_IDX_DENSITY_CTRLWORDS = 12'h45a;
	localparam logic [11:0] LCD_IDX_RESERVED_ONE = 12'h45b;
	localparam logic [11:0] LCD_IDX_RESERVED_TWO = 12'h45c;
	localparam logic [11:0] LCD_IDX_CONFIG_CHECKSUM = 12'h45d;
	localparam logic [11:0] LCD_IDX_LANE_DESKEW = 12'h46c;
	localparam logic [11:0] LCD_IDX_IRQ_STATUS = 12'h470;
	localparam logic [11:0] LCD_IDX_IRQ_MASK = 12'h471;
	localparam logic [11:0] LCD_IDX_LINK_CONTROL = 12'h472;
	localparam int LCD_ADDR_W = 14;

	// Field positions
	localparam int LCD_VER_LSB = 5;
	localparam int LCD_VER_W = 3;
	localparam int LCD_SPF_W = 5;
	localparam int LCD_HD_BIT = 7;
	localparam int LCD_CF_W = 5;
	localparam int LCD_CTL_DEFRAMER_RESET_BIT = 0;
	localparam int LCD_CTL_SKIP_ALIGN_BIT = 1;
	localparam int LCD_LANE6 = 6;
	localparam int LCD_LANES = 8;

	// Version codes
	localparam logic [2:0] LCD_VER_REV_A = 3'h0;
	localparam logic [2:0] LCD_VER_REV_B = 3'h1;

	// Reset values
	localparam logic [2:0] LCD_VER_RESET = 3'h0;
	localparam logic [4:0] LCD_SPF_RESET = 5'h01;
	localparam logic LCD_HD_RESET = 1'b1;
	localparam logic [4:0] LCD_CF_RESET = 5'h00;
	localparam logic [7:0] LCD_RES_RESET = 8'h00;
	localparam logic [7:0] LCD_CHECKSUM_RESET = 8'h00;
	localparam logic [7:0] LCD_DESKEW_RESET = 8'h00;
	localparam logic [1:0] LCD_CTL_RESET = 2'h1;

	// AHB codes
	localparam logic [1:0] LCD_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] LCD_HSIZE_WORD = 3'h2;

endpackage

//--- core/lcd_bank.sv
// Link configuration and lane deskew status register bank with AHB-Lite slave
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lcd_bank
	import lcd_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic reset_in,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// Lane status from the deframer, asynchronous
	input wire logic [LCD_LANES-1:0] lane_deskew_in,
	input wire logic lane6_sync_in,
	// Configuration to the deframer
	output logic quad_byte_deframer_reset_out,
	output logic skip_alignment_sequence_out,
	output logic [2:0] link_standard_version_out,
	output logic [7:0] reserved_byte_one_out,
	output logic [7:0] reserved_byte_two_out,
	output logic [7:0] config_checksum_out,
	// Interrupt
	output logic irq_out
);

	typedef struct packed {
		logic [LCD_LANES-1:0] sync1;
		logic [LCD_LANES-1:0] sync2;
		logic [LCD_LANES-1:0] status_prev;
		logic wr_pend;
		logic [LCD_ADDR_W-1:0] wr_addr;
		logic [2:0] version;
		logic [7:0] res_one;
		logic [7:0] res_two;
		logic [7:0] checksum;
		logic [1:0] ctl;
		logic [LCD_LANES-1:0] irq_stat;
		logic [LCD_LANES-1:0] irq_mask;
		logic [31:0] rdata;
		logic irq;
		logic ready;
		logic resp;
	} lcd_state_s;

	lcd_state_s st;
	lcd_state_s next_st;

	// Decode used for both the read and write paths
	function automatic logic addr_is(input logic [LCD_ADDR_W-1:0] a,
			input logic [11:0] idx);
		return a == {idx, 2'b00};
	endfunction

	logic [LCD_LANES-1:0] lane_raw;
	logic addr_phase;
	logic [LCD_ADDR_W-1:0] rd_addr;
	logic [LCD_LANES-1:0] rise;
	logic [LCD_LANES-1:0] wclr;
	logic [7:0] rd_byte;

	// Lane 6 carries the sync flag instead of a deskew flag
	always_comb begin
		lane_raw = lane_deskew_in;
		lane_raw[LCD_LANE6] = lane6_sync_in;
	end

	assign addr_phase = hsel_in && hready_in && htrans_in == LCD_HTRANS_NONSEQ;
	assign rd_addr = haddr_in[LCD_ADDR_W-1:0];

	always_comb begin
		next_st = st;
		rd_byte = 8'h00;
		wclr = '0;
		// Two-stage synchroniser; only sync2 is read by logic
		next_st.sync1 = lane_raw;
		next_st.sync2 = st.sync1;
		next_st.status_prev = st.sync2;
		// No wait states and no error response, kept in flops for clean outputs
		next_st.ready = 1'b1;
		next_st.resp = 1'b0;
		// Loss of deskew or sync is the event worth an interrupt
		rise = st.status_prev & ~st.sync2;
		// Write data phase
		if (st.wr_pend) begin
			if (addr_is(st.wr_addr, LCD_IDX_VERSION_SAMPLES))
				next_st.version = hwdata_in[LCD_VER_LSB +: LCD_VER_W];
			if (addr_is(st.wr_addr, LCD_IDX_RESERVED_ONE))
				next_st.res_one = hwdata_in[7:0];
			if (addr_is(st.wr_addr, LCD_IDX_RESERVED_TWO))
				next_st.res_two = hwdata_in[7:0];
			// Stored as given; the hardware does not recompute it
			if (addr_is(st.wr_addr, LCD_IDX_CONFIG_CHECKSUM))
				next_st.checksum = hwdata_in[7:0];
			if (addr_is(st.wr_addr, LCD_IDX_LINK_CONTROL))
				next_st.ctl = hwdata_in[1:0];
			if (addr_is(st.wr_addr, LCD_IDX_IRQ_MASK))
				next_st.irq_mask = hwdata_in[LCD_LANES-1:0];
			if (addr_is(st.wr_addr, LCD_IDX_IRQ_STATUS))
				wclr = hwdata_in[LCD_LANES-1:0];
		end
		// Set wins over a write-one clear in the same cycle
		next_st.irq_stat = (st.irq_stat & ~wclr) | rise;
		next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
		// Address phase
		next_st.wr_pend = addr_phase && hwrite_in;
		next_st.wr_addr = rd_addr;
		if (addr_phase && !hwrite_in) begin
			if (addr_is(rd_addr, LCD_IDX_VERSION_SAMPLES))
				rd_byte = {next_st.version, LCD_SPF_RESET};
			else if (addr_is(rd_addr, LCD_IDX_DENSITY_CTRLWORDS))
				rd_byte = {LCD_HD_RESET, 2'b00, LCD_CF_RESET};
			else if (addr_is(rd_addr, LCD_IDX_RESERVED_ONE))
				rd_byte = next_st.res_one;
			else if (addr_is(rd_addr, LCD_IDX_RESERVED_TWO))
				rd_byte = next_st.res_two;
			else if (addr_is(rd_addr, LCD_IDX_CONFIG_CHECKSUM))
				rd_byte = next_st.checksum;
			else if (addr_is(rd_addr, LCD_IDX_LANE_DESKEW))
				rd_byte = st.sync2;
			else if (addr_is(rd_addr, LCD_IDX_IRQ_STATUS))
				rd_byte = next_st.irq_stat;
			else if (addr_is(rd_addr, LCD_IDX_IRQ_MASK))
				rd_byte = next_st.irq_mask;
			else if (addr_is(rd_addr, LCD_IDX_LINK_CONTROL))
				rd_byte = {6'h00, next_st.ctl};
			next_st.rdata = {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			st.sync1 <= LCD_DESKEW_RESET;
			st.sync2 <= LCD_DESKEW_RESET;
			st.status_prev <= LCD_DESKEW_RESET;
			st.wr_pend <= 1'b0;
			st.wr_addr <= '0;
			st.version <= LCD_VER_RESET;
			st.res_one <= LCD_RES_RESET;
			st.res_two <= LCD_RES_RESET;
			st.checksum <= LCD_CHECKSUM_RESET;
			st.ctl <= LCD_CTL_RESET;
			st.irq_stat <= '0;
			st.irq_mask <= '0;
			st.rdata <= 32'h00000000;
			st.irq <= 1'b0;
			st.ready <= 1'b1;
			st.resp <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata_out = st.rdata;
	assign hreadyout_out = st.ready;
	assign hresp_out = st.resp;
	assign irq_out = st.irq;
	assign quad_byte_deframer_reset_out = st.ctl[LCD_CTL_DEFRAMER_RESET_BIT];
	// Status is meaningless to software while this is set
	assign skip_alignment_sequence_out = st.ctl[LCD_CTL_SKIP_ALIGN_BIT];
	// Fields are passed on unguarded; software keeps them stable
	assign link_standard_version_out = st.version;
	assign reserved_byte_one_out = st.res_one;
	assign reserved_byte_two_out = st.res_two;
	assign config_checksum_out = st.checksum;

	// Write reaches the version field one cycle after the data phase
	chk_version_write: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		st.wr_pend && addr_is(st.wr_addr, LCD_IDX_VERSION_SAMPLES)
		|=> link_standard_version_out == $past(hwdata_in[7:5]))
		else $error("version field not written");

	chk_version_hold: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		!(st.wr_pend && addr_is(st.wr_addr, LCD_IDX_VERSION_SAMPLES))
		|=> $stable(link_standard_version_out))
		else $error("version field changed without write");

	chk_reserved_write: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		st.wr_pend && addr_is(st.wr_addr, LCD_IDX_RESERVED_TWO)
		|=> reserved_byte_two_out == $past(hwdata_in[7:0]))
		else $error("reserved byte two not written");

	chk_res_one_write: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		st.wr_pend && addr_is(st.wr_addr, LCD_IDX_RESERVED_ONE)
		|=> reserved_byte_one_out == $past(hwdata_in[7:0]))
		else $error("reserved byte one not written");

	chk_res_one_hold: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		!(st.wr_pend && addr_is(st.wr_addr, LCD_IDX_RESERVED_ONE))
		|=> $stable(reserved_byte_one_out))
		else $error("reserved byte one changed without write");

	chk_res_two_hold: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		!(st.wr_pend && addr_is(st.wr_addr, LCD_IDX_RESERVED_TWO))
		|=> $stable(reserved_byte_two_out))
		else $error("reserved byte two changed without write");

	chk_checksum_hold: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		!(st.wr_pend && addr_is(st.wr_addr, LCD_IDX_CONFIG_CHECKSUM))
		|=> $stable(config_checksum_out))
		else $error("checksum changed without write");

	chk_checksum_write: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		st.wr_pend && addr_is(st.wr_addr, LCD_IDX_CONFIG_CHECKSUM)
		|=> config_checksum_out == $past(hwdata_in[7:0]))
		else $error("checksum not written");

	chk_checksum_read: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		addr_phase && !hwrite_in
		&& addr_is(rd_addr, LCD_IDX_CONFIG_CHECKSUM)
		|=> hrdata_out[7:0] == config_checksum_out)
		else $error("checksum read differs from field");

	chk_samples_read: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		addr_phase && !hwrite_in
		&& addr_is(rd_addr, LCD_IDX_VERSION_SAMPLES)
		|=> hrdata_out[4:0] == 5'h01)
		else $error("samples per frame not one");

	chk_density_read: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		addr_phase && !hwrite_in
		&& addr_is(rd_addr, LCD_IDX_DENSITY_CTRLWORDS)
		|=> hrdata_out[7:0] == 8'h80)
		else $error("density or control words wrong");

	// Bit 6 of the deskew input is unused and must not leak through
	chk_deskew_sync: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		##2 (st.sync2 & 8'hbf) == ($past(lane_deskew_in, 2) & 8'hbf))
		else $error("deskew status not two stages late");

	chk_deskew_read: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		addr_phase && !hwrite_in && addr_is(rd_addr, LCD_IDX_LANE_DESKEW)
		|=> hrdata_out == {24'h000000, $past(st.sync2)})
		else $error("deskew read differs from status");

	chk_lane6_sync: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		##2 st.sync2[6] == $past(lane6_sync_in, 2))
		else $error("lane 6 bit not sync status");

	chk_lane6_read: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		addr_phase && !hwrite_in && addr_is(rd_addr, LCD_IDX_LANE_DESKEW)
		|=> hrdata_out[6] == $past(st.sync2[6]))
		else $error("lane 6 read differs from sync");

	chk_read_upper: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		addr_phase && !hwrite_in
		|=> hrdata_out[31:8] == 24'h000000)
		else $error("read data upper bits not zero");

	chk_rdata_stands: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		!(addr_phase && !hwrite_in)
		|=> $stable(hrdata_out))
		else $error("read data changed without read");

	chk_ready_high: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		hreadyout_out == 1'b1)
		else $error("ready dropped");

	chk_resp_okay: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		hresp_out == 1'b0)
		else $error("response not okay");

	chk_control_write: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		st.wr_pend && addr_is(st.wr_addr, LCD_IDX_LINK_CONTROL)
		|=> {skip_alignment_sequence_out, quad_byte_deframer_reset_out}
		== $past(hwdata_in[1:0]))
		else $error("link control not written");

	chk_control_hold: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		!(st.wr_pend && addr_is(st.wr_addr, LCD_IDX_LINK_CONTROL))
		|=> $stable(quad_byte_deframer_reset_out))
		else $error("deframer reset changed without write");

	chk_mask_write: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		st.wr_pend && addr_is(st.wr_addr, LCD_IDX_IRQ_MASK)
		|=> st.irq_mask == $past(hwdata_in[7:0]))
		else $error("mask not written");

	chk_irq_clear: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		st.wr_pend && addr_is(st.wr_addr, LCD_IDX_IRQ_STATUS) && !(|rise)
		|=> (st.irq_stat & $past(hwdata_in[7:0])) == 8'h00)
		else $error("status bit not cleared");

	chk_irq_sticky: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		!(st.wr_pend && addr_is(st.wr_addr, LCD_IDX_IRQ_STATUS))
		|=> (st.irq_stat & $past(st.irq_stat)) == $past(st.irq_stat))
		else $error("status bit lost without clear");

	chk_irq_set: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		(|rise) |=> ((st.irq_stat & $past(rise)) == $past(rise)))
		else $error("status bit lost on event");

	chk_irq_level: assert property (@(posedge clk_sys_in)
		disable iff (reset_in)
		##1 irq_out == |($past(next_st.irq_stat & next_st.irq_mask)))
		else $error("irq does not follow masked status");

endmodule

`default_nettype wire

//--- dv/lcd_lane_model.sv
// Lane status model standing in for the serial transmitter side
`timescale 1ns/1ps
`default_nettype none
module lcd_lane_model (
	// Clock and wanted lane state
	input wire logic clk_sys_in,
	input wire logic [7:0] goal_in,
	input wire logic sync_goal_in,
	// Lane status toward the bank
	output logic [7:0] lane_deskew_out,
	output logic lane6_sync_out
);
	logic spare;
	initial spare = 1'b0;
	// Bit 6 carries no deskew meaning, so it toggles to expose misuse
	always @(posedge clk_sys_in) begin
		spare <= ~spare;
		lane_deskew_out <= {goal_in[7], spare, goal_in[5:0]};
		lane6_sync_out <= sync_goal_in;
	end
endmodule
`default_nettype wire

//--- dv/link_config_deskew_status_test.sv
// Self-checking bench for the link configuration bank
`timescale 1ns/1ps
`default_nettype none
module link_config_deskew_status_test;
	import lcd_pkg::*;
	logic clk_sys_in = 0, reset_in = 1, hsel = 0, hwrite = 0, sync_goal = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic hready, hresp, irq, rst_o, skip_o, sync6;
	logic [2:0] ver_o;
	logic [7:0] goal = 8'h00, lanes, r1_o, r2_o, ck_o, a, b, sum;
	logic [11:0] ix [8] = '{12'h459, 12'h45a, 12'h45b, 12'h45c, 12'h45d,
		12'h46c, 12'h472, 12'h460};
	logic [7:0] rv [8] = '{8'h01, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
		8'h00};
	int err_total = 0, total_checks = 0, cyc = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	lcd_lane_model i_far (.clk_sys_in(clk_sys_in), .goal_in(goal),
		.sync_goal_in(sync_goal), .lane_deskew_out(lanes),
		.lane6_sync_out(sync6));
	lcd_bank i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(LCD_HSIZE_WORD), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .lane_deskew_in(lanes), .lane6_sync_in(sync6),
		.quad_byte_deframer_reset_out(rst_o),
		.skip_alignment_sequence_out(skip_o),
		.link_standard_version_out(ver_o), .reserved_byte_one_out(r1_o),
		.reserved_byte_two_out(r2_o), .config_checksum_out(ck_o),
		.irq_out(irq));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdy;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
	endtask
	// Address phase held until hready, then data phase until hready
	task automatic xfer(input logic [11:0] idx, input logic wr,
		input logic [7:0] d);
		@(posedge clk_sys_in);
		hsel <= 1;
		haddr <= {18'h0, idx, 2'b00};
		htrans <= LCD_HTRANS_NONSEQ;
		hwrite <= wr;
		rdy;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		rdy;
		q = hrdata;
	endtask
	function automatic logic [31:0] exp_desk(logic [7:0] d, logic s);
		return {24'h0, d[7], s, d[5:0]};
	endfunction
	function automatic logic [31:0] exp_ver(logic [7:0] d);
		return {24'h0, d[7:5], LCD_SPF_RESET};
	endfunction
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			err_total++;
			end_sim;
		end
	end
	initial begin
		void'($urandom(55));
		repeat (12) @(posedge clk_sys_in);
		reset_in <= 0;
		for (int i = 0; i < 8; i++) begin
			xfer(ix[i], 0, 0);
			chk("reset read", {24'h0, rv[i]}, q);
		end
		chk("hresp", 0, hresp);
		$display("test reset values done");
		// Fields are programmed while the deframer is held in reset
		for (int i = 0; i < 2; i++) begin
			a = {(i ? LCD_VER_REV_B : LCD_VER_REV_A), 5'($urandom)};
			xfer(LCD_IDX_VERSION_SAMPLES, 1, a);
			xfer(LCD_IDX_VERSION_SAMPLES, 0, 0);
			chk("version", exp_ver(a), q);
			chk("version out", a[7:5], ver_o);
		end
		xfer(LCD_IDX_DENSITY_CTRLWORDS, 1, 8'h1f);
		xfer(LCD_IDX_DENSITY_CTRLWORDS, 0, 0);
		chk("density", 32'h80, q);
		a = 8'($urandom);
		b = 8'($urandom);
		xfer(LCD_IDX_RESERVED_ONE, 1, a);
		xfer(LCD_IDX_RESERVED_TWO, 1, b);
		xfer(LCD_IDX_RESERVED_ONE, 0, 0);
		chk("res one", {24'h0, a}, q);
		xfer(LCD_IDX_RESERVED_TWO, 0, 0);
		chk("res two", {24'h0, b}, q);
		chk("res outs", {a, b}, {r1_o, r2_o});
		sum = 8'(exp_ver(8'h20) + 8'h80 + a + b);
		xfer(LCD_IDX_CONFIG_CHECKSUM, 1, sum);
		xfer(LCD_IDX_CONFIG_CHECKSUM, 0, 0);
		chk("checksum", {24'h0, sum}, q);
		chk("checksum out", sum, ck_o);
		xfer(LCD_IDX_LINK_CONTROL, 1, 8'h02);
		xfer(LCD_IDX_LINK_CONTROL, 0, 0);
		chk("control", 32'h02, q);
		chk("control outs", 2'b01, {rst_o, skip_o});
		$display("test configuration done");
		for (int i = 0; i < 6; i++) begin
			goal <= 8'($urandom);
			sync_goal <= 1'($urandom);
			repeat (4) @(posedge clk_sys_in);
			xfer(LCD_IDX_LANE_DESKEW, 0, 0);
			chk("deskew", exp_desk(goal, sync_goal), q);
		end
		$display("test lane status done");
		// Status bits are sticky, so clear whatever the random lanes left
		goal <= 8'hff;
		sync_goal <= 1;
		repeat (6) @(posedge clk_sys_in);
		xfer(LCD_IDX_IRQ_STATUS, 1, 8'hff);
		xfer(LCD_IDX_IRQ_MASK, 1, 8'hff);
		chk("irq idle", 0, irq);
		goal <= 8'hfb;
		repeat (6) @(posedge clk_sys_in);
		chk("irq raised", 1, irq);
		xfer(LCD_IDX_IRQ_STATUS, 0, 0);
		chk("irq status", 32'h04, q);
		xfer(LCD_IDX_IRQ_MASK, 1, 8'h00);
		repeat (2) @(posedge clk_sys_in);
		chk("irq masked", 0, irq);
		xfer(LCD_IDX_IRQ_MASK, 1, 8'hff);
		xfer(LCD_IDX_IRQ_STATUS, 1, 8'h04);
		repeat (2) @(posedge clk_sys_in);
		chk("irq cleared", 0, irq);
		xfer(LCD_IDX_IRQ_STATUS, 0, 0);
		chk("status cleared", 0, q);
		$display("test interrupt done");
		end_sim;
	end
endmodule
`default_nettype wire
